// ===== hw/gain_routing_map.svh
// Purpose: Offsets, fields, reset values and timing counts for the output gain and routing block
// Assumes: Classic Wishbone, 32-bit data, byte addresses
// Notes:   Included by the package and the testbench
`ifndef GAIN_ROUTING_MAP_SVH
`define GAIN_ROUTING_MAP_SVH

`define OFS_CTRL          6'h00
`define OFS_ATTEN         6'h04
`define OFS_GAIN          6'h08
`define OFS_STATUS        6'h0c
`define OFS_CUR_ATTEN     6'h10

`define CTRL_CFG_LO       0
`define CTRL_SPEED_BIT    2
`define CTRL_SLIDER_BIT   3

`define CFG_RESET         2'h0
`define ATTEN_MUTE        8'hff
`define GAIN_RESET        2'h0

`define CLK_HZ            25000000
`define FS_HZ             48000
`define SILENCE_MS        2
`define SILENCE_CYCLES    ((`CLK_HZ / 1000) * `SILENCE_MS)
`define SLOW_STEP_FS      4
`define FAST_STEP_FS      1

`endif

// ===== hw/gain_routing_pkg.sv
// Purpose: Types for the output gain and routing block
// Assumes: Map header supplies every number
// Notes:   Sample width fixed at 24 bits
`include "gain_routing_map.svh"

package gain_routing_pkg;
    typedef logic signed [23:0] sample_t;
    typedef enum logic [1:0] {
        CFG_DIFF_STEREO,
        CFG_SUM_STEREO,
        CFG_TWO_ONE,
        CFG_FOUR_CHAN
    } out_cfg_e;
    typedef enum {
        SIL_RUN,
        SIL_SWITCH,
        SIL_WAIT
    } silence_e;
endpackage : gain_routing_pkg

// ===== hw/audio_output_gain_routing.sv
// Purpose: Attenuator, fixed gains, bypass muting and DAC routing of the codec output stage
// Assumes: fs_tick_i is a one-cycle strobe per sample; samples are valid at that strobe
// Notes:   Filters, equalizers and limiters live outside; this block applies their gain steps
//
// Decided for this implementation: the Wishbone slave port and the address map.
module audio_output_gain_routing
    import gain_routing_pkg::*;
#(
    parameter int SILENCE_CYCLES = `SILENCE_CYCLES
) (
    // Clock and reset
    input  wire logic        clk_i,
    input  wire logic        rst_i,
    input  wire logic        powerdown_pin_n_i,
    // Wishbone slave
    input  wire logic        cyc_i,
    input  wire logic        stb_i,
    input  wire logic        we_i,
    input  wire logic [5:0]  adr_i,
    input  wire logic [3:0]  sel_i,
    input  wire logic [31:0] dat_i,
    output logic      [31:0] dat_o,
    output logic             ack_o,
    // Control pins
    input  wire logic        bypass_i,
    input  wire logic [7:0]  slider_code_i,
    // Sample streams
    input  wire logic        fs_tick_i,
    input  wire sample_t     chain_one_left_i,
    input  wire sample_t     chain_one_right_i,
    input  wire sample_t     chain_two_left_i,
    input  wire sample_t     chain_two_right_i,
    input  wire sample_t     chain_two_mono_i,
    input  wire sample_t     direct_left_i,
    input  wire sample_t     direct_right_i,
    // Converter and amplifier outputs
    output sample_t          conv_a_left_o,
    output sample_t          conv_a_right_o,
    output sample_t          conv_b_left_o,
    output sample_t          conv_b_right_o,
    output logic             amp_silence_out_o
);
    // Registers and datapath are held in reset by either the bus reset or the power-down pin; the bus ack and read data by the bus reset only
    wire logic        hold_w = rst_i | ~powerdown_pin_n_i;

    logic [1:0]  output_config_sel_r;
    logic        atten_ramp_speed_r;
    logic        slider_conv_power_r;
    logic [7:0]  left_atten_code_r;
    logic [7:0]  right_atten_code_r;
    logic [1:0]  chain_one_pre_gain_r;
    logic [1:0]  chain_two_pre_gain_r;
    logic [1:0]  chain_one_post_gain_r;
    logic [1:0]  chain_two_post_gain_r;
    logic [1:0]  cfg_live_r;
    logic [7:0]  cur_atten_r [2];
    logic [1:0]  step_cnt_r;
    logic        bypass_seen_r;
    logic        bypass_live_r;
    silence_e    sil_state_r;
    logic [31:0] sil_cnt_r;
    logic        amp_on_r;

    // Bus decode
    wire logic        req_w     = cyc_i & stb_i & ~ack_o;
    wire logic        wr_w      = req_w & we_i & sel_i[0];
    wire logic        wr_ctrl_w = wr_w & (adr_i == `OFS_CTRL);
    wire logic        wr_att_w  = wr_w & (adr_i == `OFS_ATTEN);
    wire logic        wr_gain_w = wr_w & (adr_i == `OFS_GAIN);
    wire logic [31:0] rd_w =
        (adr_i == `OFS_CTRL)      ? {28'h0, slider_conv_power_r, atten_ramp_speed_r,
                                     output_config_sel_r} :
        (adr_i == `OFS_ATTEN)     ? {16'h0, right_atten_code_r, left_atten_code_r} :
        (adr_i == `OFS_GAIN)      ? {24'h0, chain_two_post_gain_r, chain_one_post_gain_r,
                                     chain_two_pre_gain_r, chain_one_pre_gain_r} :
        (adr_i == `OFS_STATUS)    ? {28'h0, amp_on_r, bypass_live_r, cfg_live_r} :
        (adr_i == `OFS_CUR_ATTEN) ? {16'h0, cur_atten_r[1], cur_atten_r[0]} :
                                    32'h0;

    always_ff @(posedge clk_i) begin
        ack_o <= ~rst_i & req_w;
        dat_o <= (~rst_i & req_w & ~we_i) ? rd_w : 32'h0;
    end

    // Registers; power-down returns them to defaults, attenuation to mute
    always_ff @(posedge clk_i) begin
        if (hold_w) begin
            output_config_sel_r   <= `CFG_RESET;
            atten_ramp_speed_r    <= 1'b0;
            slider_conv_power_r   <= 1'b0;
            left_atten_code_r     <= `ATTEN_MUTE;
            right_atten_code_r    <= `ATTEN_MUTE;
            chain_one_pre_gain_r  <= `GAIN_RESET;
            chain_two_pre_gain_r  <= `GAIN_RESET;
            chain_one_post_gain_r <= `GAIN_RESET;
            chain_two_post_gain_r <= `GAIN_RESET;
        end else begin
            if (wr_ctrl_w) begin
                output_config_sel_r <= dat_i[`CTRL_CFG_LO +: 2];
                atten_ramp_speed_r  <= dat_i[`CTRL_SPEED_BIT];
                slider_conv_power_r <= dat_i[`CTRL_SLIDER_BIT];
            end
            if (wr_att_w) begin
                left_atten_code_r <= dat_i[7:0];
                if (sel_i[1]) begin
                    right_atten_code_r <= dat_i[15:8];
                end
            end
            // Applied straight to the datapath, no smoothing
            if (wr_gain_w) begin
                chain_one_pre_gain_r  <= dat_i[1:0];
                chain_two_pre_gain_r  <= dat_i[3:2];
                chain_one_post_gain_r <= dat_i[5:4];
                chain_two_post_gain_r <= dat_i[7:6];
            end
        end
    end

    // Attenuation target: slider result overrides the register codes
    wire logic [7:0] tgt_w [2];
    assign tgt_w[0] = slider_conv_power_r ? slider_code_i : left_atten_code_r;
    assign tgt_w[1] = slider_conv_power_r ? slider_code_i : right_atten_code_r;

    // Step pacing: every fourth sample when slow, every sample when fast
    wire logic [1:0] step_last_w = atten_ramp_speed_r ? 2'(`FAST_STEP_FS - 1)
                                                      : 2'(`SLOW_STEP_FS - 1);
    wire logic       step_w      = fs_tick_i & (step_cnt_r >= step_last_w);

    always_ff @(posedge clk_i) begin
        if (hold_w) begin
            step_cnt_r <= 2'h0;
        end else if (fs_tick_i) begin
            step_cnt_r <= step_w ? 2'h0 : step_cnt_r + 2'h1;
        end
    end

    // One channel of the output attenuator per generate entry
    sample_t att_out_w [2];
    sample_t att_in_w  [2];
    assign att_in_w[0] = direct_left_i;
    assign att_in_w[1] = direct_right_i;

    for (genvar ch = 0; ch < 2; ch++) begin : g_att
        always_ff @(posedge clk_i) begin
            if (hold_w) begin
                cur_atten_r[ch] <= `ATTEN_MUTE;
            end else if (step_w && cur_atten_r[ch] < tgt_w[ch]) begin
                cur_atten_r[ch] <= cur_atten_r[ch] + 8'h1;
            end else if (step_w && cur_atten_r[ch] > tgt_w[ch]) begin
                cur_atten_r[ch] <= cur_atten_r[ch] - 8'h1;
            end
        end
        // Approximation: 6 dB per 12 codes by shift, finer steps by a linear trim
        // Code 0 passes the sample untouched; the trim runs from 128/128 toward one half
        wire logic [4:0]  sh_w   = 5'(cur_atten_r[ch] / 8'd12);
        wire logic [3:0]  fr_w   = 4'(cur_atten_r[ch] % 8'd12);
        wire logic signed [31:0] sh_v = 32'(signed'(att_in_w[ch] >>> sh_w));
        wire logic signed [31:0] fr_k = 32'sd128 - 32'sd5 * 32'(signed'({1'b0, fr_w}));
        wire logic signed [31:0] fr_v = (sh_v * fr_k) >>> 7;
        assign att_out_w[ch] = (cur_atten_r[ch] == `ATTEN_MUTE) ? 24'sh0 : 24'(fr_v);
    end

    // Fixed gain steps in unsigned Q5.8; both steps together reach about 20x
    function automatic sample_t apply_gain(input sample_t s, input logic [12:0] g);
        logic signed [39:0] p;
        logic signed [39:0] lim;
        p = (40'(s) * 40'(signed'({1'b0, g}))) >>> 8;
        // Saturate rather than wrap, so a large gain clips instead of flipping sign
        if (p > 40'sh7fffff) begin
            lim = 40'sh7fffff;
        end else if (p < -40'sh800000) begin
            lim = -40'sh800000;
        end else begin
            lim = p;
        end
        return 24'(lim);
    endfunction : apply_gain

    function automatic logic [11:0] pre_mult(input logic [1:0] c);
        case (c)
            2'h1:    pre_mult = 12'h200;
            2'h2:    pre_mult = 12'h3fd;
            2'h3:    pre_mult = 12'h809;
            default: pre_mult = 12'h100;
        endcase
    endfunction : pre_mult

    function automatic logic [9:0] post_mult(input logic [1:0] c);
        case (c)
            2'h1:    post_mult = 10'h17f;
            2'h2:    post_mult = 10'h1ff;
            2'h3:    post_mult = 10'h283;
            default: post_mult = 10'h100;
        endcase
    endfunction : post_mult

    wire logic [11:0] pre1_w  = pre_mult(chain_one_pre_gain_r);
    wire logic [11:0] pre2_w  = pre_mult(chain_two_pre_gain_r);
    wire logic [9:0]  post1_w = post_mult(chain_one_post_gain_r);
    wire logic [9:0]  post2_w = post_mult(chain_two_post_gain_r);
    wire logic [12:0] g1_w    = 13'(({12'h0, pre1_w} * {14'h0, post1_w}) >> 8);
    wire logic [12:0] g2_w    = 13'(({12'h0, pre2_w} * {14'h0, post2_w}) >> 8);

    // Five chain inputs share one gain shape: entries 0-1 chain one, entries 2-4 chain two.
    // Bypass takes the attenuator output directly; the mono entry follows the left channel.
    sample_t          chain_in_w   [5];
    sample_t          chain_byp_w  [5];
    sample_t          chain_out_w  [5];
    wire logic [12:0] chain_gain_w [5];
    assign chain_in_w[0]   = chain_one_left_i;
    assign chain_in_w[1]   = chain_one_right_i;
    assign chain_in_w[2]   = chain_two_left_i;
    assign chain_in_w[3]   = chain_two_right_i;
    assign chain_in_w[4]   = chain_two_mono_i;
    assign chain_byp_w[0]  = att_out_w[0];
    assign chain_byp_w[1]  = att_out_w[1];
    assign chain_byp_w[2]  = att_out_w[0];
    assign chain_byp_w[3]  = att_out_w[1];
    assign chain_byp_w[4]  = att_out_w[0];
    assign chain_gain_w[0] = g1_w;
    assign chain_gain_w[1] = g1_w;
    assign chain_gain_w[2] = g2_w;
    assign chain_gain_w[3] = g2_w;
    assign chain_gain_w[4] = g2_w;

    for (genvar k = 0; k < 5; k++) begin : g_chain
        assign chain_out_w[k] = bypass_live_r ? chain_byp_w[k]
                              : apply_gain(chain_in_w[k], chain_gain_w[k]);
    end

    wire sample_t c1l_w = chain_out_w[0];
    wire sample_t c1r_w = chain_out_w[1];
    wire sample_t c2l_w = chain_out_w[2];
    wire sample_t c2r_w = chain_out_w[3];
    wire sample_t c2m_w = chain_out_w[4];
    wire sample_t sum_l_w = 24'((25'(c1l_w) + 25'(c2l_w)) >>> 1);
    wire sample_t sum_r_w = 24'((25'(c1r_w) + 25'(c2r_w)) >>> 1);

    // Routing table
    sample_t r_al_w, r_ar_w, r_bl_w, r_br_w;
    always_comb begin
        case (out_cfg_e'(cfg_live_r))
            CFG_DIFF_STEREO: begin
                r_al_w = c1l_w;
                r_ar_w = -c1l_w;
                r_bl_w = c1r_w;
                r_br_w = -c1r_w;
            end
            CFG_SUM_STEREO: begin
                r_al_w = sum_l_w;
                r_ar_w = -sum_l_w;
                r_bl_w = sum_r_w;
                r_br_w = -sum_r_w;
            end
            CFG_TWO_ONE: begin
                r_al_w = c1l_w;
                r_ar_w = c1r_w;
                r_bl_w = c2m_w;
                r_br_w = -c2m_w;
            end
            default: begin
                r_al_w = c1l_w;
                r_ar_w = c1r_w;
                r_bl_w = c2l_w;
                r_br_w = c2r_w;
            end
        endcase
    end

    // Config and outputs only move on the sample strobe
    always_ff @(posedge clk_i) begin
        if (hold_w) begin
            cfg_live_r     <= `CFG_RESET;
            conv_a_left_o  <= 24'sh0;
            conv_a_right_o <= 24'sh0;
            conv_b_left_o  <= 24'sh0;
            conv_b_right_o <= 24'sh0;
        end else if (fs_tick_i) begin
            cfg_live_r     <= output_config_sel_r;
            conv_a_left_o  <= r_al_w;
            conv_a_right_o <= r_ar_w;
            conv_b_left_o  <= r_bl_w;
            conv_b_right_o <= r_br_w;
        end
    end

    // Bypass sequencing: silence first, switch one cycle later, then hold off 2 ms
    always_ff @(posedge clk_i) begin
        if (hold_w) begin
            sil_state_r   <= SIL_WAIT;
            bypass_seen_r <= 1'b0;
            bypass_live_r <= 1'b0;
            sil_cnt_r     <= 32'h0;
            amp_on_r      <= 1'b0;
        end else begin
            bypass_seen_r <= bypass_i;
            case (sil_state_r)
                SIL_RUN: begin
                    if (bypass_i != bypass_live_r) begin
                        amp_on_r    <= 1'b0;
                        sil_state_r <= SIL_SWITCH;
                    end
                end
                SIL_SWITCH: begin
                    bypass_live_r <= bypass_seen_r;
                    sil_cnt_r     <= 32'h0;
                    sil_state_r   <= SIL_WAIT;
                end
                SIL_WAIT: begin
                    if (bypass_i != bypass_live_r) begin
                        sil_state_r <= SIL_SWITCH;
                    end else if (sil_cnt_r >= 32'(SILENCE_CYCLES - 1)) begin
                        amp_on_r    <= 1'b1;
                        sil_state_r <= SIL_RUN;
                    end else begin
                        sil_cnt_r <= sil_cnt_r + 32'h1;
                    end
                end
                default: sil_state_r <= SIL_WAIT;
            endcase
        end
    end

    assign amp_silence_out_o = amp_on_r;
    // two gain chains and the single attenuator above
endmodule : audio_output_gain_routing

// ===== testbench/output_stage_sva.sv
// Purpose: Port checks of the output gain and routing stage
// Assumes: Sync resets, one clock
// Notes:   Bound from the tb top file
module output_stage_sva
    import gain_routing_pkg::*;
#(
    parameter int SILENCE_CYCLES = 20
) (
    // Clock and reset
    input wire logic        clk_i,
    input wire logic        rst_i,
    input wire logic        powerdown_pin_n_i,
    // Bus
    input wire logic        cyc_i,
    input wire logic        stb_i,
    input wire logic [31:0] dat_o,
    input wire logic        ack_o,
    // Pins and samples
    input wire logic        bypass_i,
    input wire logic        fs_tick_i,
    input wire sample_t     conv_a_left_o,
    input wire sample_t     conv_b_right_o,
    input wire logic        amp_silence_out_o
);
    // Generous bound, only meant to catch an amplifier that never unmutes
    localparam int RISE_MAX = 1000;
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (rst_i);
    property p_ack_once; ack_o |=> !ack_o; endproperty
    a_ack_once: assert property (p_ack_once) else $error("ack held too long");
    property p_ack_lat; cyc_i && stb_i && !ack_o && powerdown_pin_n_i |=> ack_o; endproperty
    a_ack_lat: assert property (p_ack_lat) else $error("ack not one cycle after request");
    property p_ack_cause; ack_o |-> $past(cyc_i && stb_i); endproperty
    a_ack_cause: assert property (p_ack_cause) else $error("ack without request");
    property p_dat_zero; !ack_o |-> dat_o == 32'h0; endproperty
    a_dat_zero: assert property (p_dat_zero) else $error("read data outside ack");
    property p_byp_mute; $changed(bypass_i) |=> !amp_silence_out_o; endproperty
    a_byp_mute: assert property (p_byp_mute) else $error("amp not muted on bypass edge");
    property p_amp_hold; $fell(amp_silence_out_o) |-> !amp_silence_out_o [*8]; endproperty
    a_amp_hold: assert property (p_amp_hold) else $error("amp unmuted too soon");
    property p_amp_rise; $changed(bypass_i) |-> ##[1:RISE_MAX] amp_silence_out_o; endproperty
    a_amp_rise: assert property (p_amp_rise) else $error("amp never unmuted");
    property p_out_hold;
        !fs_tick_i && powerdown_pin_n_i |=> $stable(conv_a_left_o) && $stable(conv_b_right_o);
    endproperty
    a_out_hold: assert property (p_out_hold) else $error("output moved off a tick");
    property p_pdn_amp; !powerdown_pin_n_i |=> !amp_silence_out_o; endproperty
    a_pdn_amp: assert property (p_pdn_amp) else $error("amp live in power-down");
endmodule : output_stage_sva

// ===== testbench/dac_amp_model.sv
// Purpose: Far side: the four converters; the speaker amplifier enable is not an input
// Assumes: One word per converter per sample tick
// Notes:   Frame is taken one edge after the tick edge
module dac_amp_model
    import gain_routing_pkg::*;
(
    // Clock and stream
    input  wire logic    clk_i,
    input  wire logic    fs_tick_i,
    input  wire sample_t a_left_i,
    input  wire sample_t a_right_i,
    input  wire sample_t b_left_i,
    input  wire sample_t b_right_i,
    // Heard frame
    output sample_t      heard_o [4]
);
    logic tick_d_r;
    always_ff @(posedge clk_i) begin
        tick_d_r <= fs_tick_i;
        if (tick_d_r) begin
            heard_o <= '{a_left_i, a_right_i, b_left_i, b_right_i};
        end
    end
endmodule : dac_amp_model

// ===== testbench/tb.sv
// Purpose: Self-checking bench of the output gain and routing stage
// Assumes: Shortened silence count of 20 cycles
// Notes:   Bus and tick helpers are shared by all scenarios
`include "gain_routing_map.svh"
module tb
    import gain_routing_pkg::*;
();
    timeunit 1ns;
    timeprecision 1ps;
    localparam int SIL = 20;
    localparam sample_t L1 = 24'h001000, R1 = 24'h000200, L2 = 24'h000300;
    localparam sample_t R2 = 24'h000040, MN = 24'h000050, DL = 24'h000111, DR = 24'h000222;
    logic clk_i = 0, rst_i = 1, powerdown_pin_n_i = 1, cyc_i = 0, stb_i = 0, we_i = 0;
    logic [5:0] adr_i = 0;
    logic [3:0] sel_i = 4'hf;
    logic [31:0] dat_i = 0, dat_o;
    logic ack_o, amp_silence_out_o, bypass_i = 0, fs_tick_i = 0;
    logic [7:0] slider_code_i = 8'h10;
    sample_t chain_one_left_i = L1, chain_one_right_i = R1, chain_two_left_i = L2;
    sample_t chain_two_right_i = R2, chain_two_mono_i = MN;
    sample_t direct_left_i = DL, direct_right_i = DR;
    sample_t conv_a_left_o, conv_a_right_o, conv_b_left_o, conv_b_right_o, e [4], heard [4];
    int fail_count = 0, tests_run = 0;
    audio_output_gain_routing #(.SILENCE_CYCLES(SIL)) dut (.clk_i, .rst_i, .powerdown_pin_n_i,
        .cyc_i, .stb_i, .we_i, .adr_i, .sel_i, .dat_i, .dat_o, .ack_o, .bypass_i,
        .slider_code_i, .fs_tick_i, .chain_one_left_i, .chain_one_right_i, .chain_two_left_i,
        .chain_two_right_i, .chain_two_mono_i, .direct_left_i, .direct_right_i, .conv_a_left_o,
        .conv_a_right_o, .conv_b_left_o, .conv_b_right_o, .amp_silence_out_o);
    dac_amp_model u_dac (.clk_i, .fs_tick_i, .a_left_i(conv_a_left_o),
        .a_right_i(conv_a_right_o), .b_left_i(conv_b_left_o), .b_right_i(conv_b_right_o),
        .heard_o(heard));
    initial begin
        forever #20 clk_i = ~clk_i;
    end
    task automatic complete_run();
        $display("Counts: %0d compared, %0d mismatched", tests_run, fail_count);
        if (fail_count == 0 && tests_run > 0) $display("Simulation passed");
        else $display("Simulation failed");
        $finish;
    endtask : complete_run
    task automatic chk(input logic [31:0] exp, input logic [31:0] got);
        tests_run++;
        if (got !== exp) begin
            fail_count++;
            $display("MISMATCH t=%0t exp=%h got=%h", $time, exp, got);
        end
    endtask : chk
    task automatic chk_near(input logic signed [31:0] exp, input logic signed [31:0] got);
        logic signed [31:0] d;
        tests_run++;
        d = got - exp;
        // Fixed-point gain steps are approximate: allow 1/128 of the expected magnitude
        if (((d <= exp / 128 + 1) && (d >= -(exp / 128) - 1)) !== 1'b1) begin
            fail_count++;
            $display("MISMATCH t=%0t exp=%h got=%h", $time, exp, got);
        end
    endtask : chk_near
    function automatic logic signed [31:0] db_gain(input sample_t s, input real db);
        return 32'($rtoi($itor(s) * 10.0 ** (db / 20.0)));
    endfunction : db_gain
    task automatic wb(input logic w, input logic [5:0] a, input logic [31:0] d,
                      output logic [31:0] q);
        @(posedge clk_i);
        cyc_i <= 1'b1;
        stb_i <= 1'b1;
        we_i <= w;
        adr_i <= a;
        dat_i <= d;
        // Request stands until the edge at which ack is seen; only the watchdog ends a hang
        do begin
            @(posedge clk_i);
        end while (ack_o !== 1'b1);
        q = dat_o;
        cyc_i <= 1'b0;
        stb_i <= 1'b0;
    endtask : wb
    task automatic wr(input logic [5:0] a, input logic [31:0] d);
        logic [31:0] q;
        wb(1'b1, a, d, q);
    endtask : wr
    task automatic rd(input logic [5:0] a, input logic [31:0] exp);
        logic [31:0] q;
        wb(1'b0, a, 32'h0, q);
        chk(exp, q);
    endtask : rd
    task automatic tick(input int n);
        repeat (n) begin
            @(posedge clk_i);
            fs_tick_i <= 1'b1;
            @(posedge clk_i);
            fs_tick_i <= 1'b0;
        end
        @(posedge clk_i);
        #1;
    endtask : tick
    task automatic t_reset();
        rd(`OFS_CTRL, 32'h0);
        rd(`OFS_CUR_ATTEN, 32'hffff);
        rd(`OFS_GAIN, 32'h0);
        rd(6'h3c, 32'h0);
        repeat (SIL + 4) @(posedge clk_i);
        #1 chk(32'h1, {31'h0, amp_silence_out_o});
        $display("test reset done");
    endtask : t_reset
    task automatic t_ramp();
        wr(`OFS_CTRL, 32'h4);
        wr(`OFS_ATTEN, 32'h0);
        tick(10);
        rd(`OFS_CUR_ATTEN, 32'hf5f5);
        wr(`OFS_CTRL, 32'h0);
        tick(8);
        rd(`OFS_CUR_ATTEN, 32'hf3f3);
        wr(`OFS_CTRL, 32'h4);
        tick(250);
        rd(`OFS_CUR_ATTEN, 32'h0);
        wr(`OFS_CTRL, 32'hc);
        tick(20);
        rd(`OFS_CUR_ATTEN, 32'h1010);
        wr(`OFS_CTRL, 32'h4);
        tick(20);
        rd(`OFS_CUR_ATTEN, 32'h0);
        $display("test ramp done");
    endtask : t_ramp
    task automatic t_route();
        for (int c = 0; c < 4; c++) begin
            wr(`OFS_CTRL, 32'(c) | 32'h4);
            tick(2);
            case (c)
                0: e = '{L1, -L1, R1, -R1};
                1: e = '{(L1 + L2) >>> 1, -((L1 + L2) >>> 1), (R1 + R2) >>> 1, -((R1 + R2) >>> 1)};
                2: e = '{L1, R1, MN, -MN};
                default: e = '{L1, R1, L2, R2};
            endcase
            for (int k = 0; k < 4; k++) chk({8'h0, e[k]}, {8'h0, heard[k]});
        end
        wr(`OFS_GAIN, 32'h1);
        tick(1);
        e = '{L1 <<< 1, R1 <<< 1, L2, R2};
        for (int k = 0; k < 4; k++) chk({8'h0, e[k]}, {8'h0, heard[k]});
        wr(`OFS_GAIN, 32'hdb);
        tick(1);
        chk_near(db_gain(L1, 21.6), 32'(heard[0]));
        chk_near(db_gain(R1, 21.6), 32'(heard[1]));
        chk_near(db_gain(L2, 20.0), 32'(heard[2]));
        chk_near(db_gain(R2, 20.0), 32'(heard[3]));
        wr(`OFS_GAIN, 32'h0);
        $display("test route done");
    endtask : t_route
    task automatic t_bypass();
        @(posedge clk_i);
        bypass_i <= 1'b1;
        repeat (2) @(posedge clk_i);
        #1 chk(32'h0, {31'h0, amp_silence_out_o});
        tick(2);
        chk({8'h0, DL, 8'h0, DR}, {8'h0, heard[0], 8'h0, heard[1]});
        repeat (SIL + 4) @(posedge clk_i);
        #1 chk(32'h1, {31'h0, amp_silence_out_o});
        @(posedge clk_i);
        bypass_i <= 1'b0;
        repeat (2) @(posedge clk_i);
        #1 chk(32'h0, {31'h0, amp_silence_out_o});
        tick(2);
        chk({8'h0, L1, 8'h0, R1}, {8'h0, heard[0], 8'h0, heard[1]});
        @(posedge clk_i);
        powerdown_pin_n_i <= 1'b0;
        repeat (2) @(posedge clk_i);
        powerdown_pin_n_i <= 1'b1;
        #1 chk(32'h0, {31'h0, amp_silence_out_o});
        rd(`OFS_CUR_ATTEN, 32'hffff);
        repeat (SIL + 4) @(posedge clk_i);
        #1 chk(32'h1, {31'h0, amp_silence_out_o});
        $display("test bypass done");
    endtask : t_bypass
    initial begin
        #(40 * 20000);
        fail_count++;
        complete_run();
    end
    initial begin
        repeat (3) @(posedge clk_i);
        rst_i <= 1'b0;
        t_reset();
        t_ramp();
        t_route();
        t_bypass();
        complete_run();
    end
endmodule : tb
bind audio_output_gain_routing output_stage_sva #(.SILENCE_CYCLES(SILENCE_CYCLES)) u_sva (
    .clk_i(clk_i), .rst_i(rst_i), .powerdown_pin_n_i(powerdown_pin_n_i), .cyc_i(cyc_i),
    .stb_i(stb_i), .dat_o(dat_o), .ack_o(ack_o), .bypass_i(bypass_i), .fs_tick_i(fs_tick_i),
    .conv_a_left_o(conv_a_left_o), .conv_b_right_o(conv_b_right_o),
    .amp_silence_out_o(amp_silence_out_o));
